// [hdl/idec_pkg.sv]
/*
  Constants and types for the instruction length, effective address
  and branch decoder of an 8-bit controller CPU.
  Assumes the fetch unit supplies up to three instruction bytes at once.
*/
package idec_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // low-page high byte
  localparam logic [7:0] ZERO_PAGE_HI = 8'h00;

  // opcode field positions
  localparam int OPC_ROW_HI = 7;
  localparam int OPC_ROW_LO = 4;
  localparam int OPC_COL_HI = 3;
  localparam int OPC_COL_LO = 0;
  localparam int BIT_NUM_HI = 3;
  localparam int BIT_NUM_LO = 1;
  localparam int BIT_SENSE  = 0;

  // opcode rows
  localparam logic [3:0] ROW_BIT_BRANCH = 4'h0;
  localparam logic [3:0] ROW_BIT_MANIP  = 4'h1;
  localparam logic [3:0] ROW_BRANCH     = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR    = 4'h3;
  localparam logic [3:0] ROW_RMW_ACC    = 4'h4;
  localparam logic [3:0] ROW_RMW_IDX    = 4'h5;
  localparam logic [3:0] ROW_RMW_IX1    = 4'h6;
  localparam logic [3:0] ROW_RMW_IX     = 4'h7;
  localparam logic [3:0] ROW_CTRL_A     = 4'h8;
  localparam logic [3:0] ROW_CTRL_B     = 4'h9;
  localparam logic [3:0] ROW_RM_IMM     = 4'hA;
  localparam logic [3:0] ROW_RM_DIR     = 4'hB;
  localparam logic [3:0] ROW_RM_EXT     = 4'hC;
  localparam logic [3:0] ROW_RM_IX2     = 4'hD;
  localparam logic [3:0] ROW_RM_IX1     = 4'hE;
  localparam logic [3:0] ROW_RM_IX      = 4'hF;

  // special columns
  localparam logic [3:0] COL_RMW_TEST          = 4'hD;
  localparam logic [3:0] COL_RM_STA            = 4'h7;
  localparam logic [3:0] COL_RM_STX            = 4'hF;
  localparam logic [3:0] COL_BRANCH_SUBROUTINE = 4'hD;
  localparam logic [3:0] COL_INDEX_COMPARE     = 4'h3;
  localparam logic [3:0] COL_UNCOND_JUMP       = 4'hC;
  localparam logic [3:0] COL_JUMP_SUBROUTINE   = 4'hD;
  localparam logic [3:0] COL_LDX               = 4'hE;
  localparam logic [7:0] OPC_MULTIPLY          = 8'h42;

  typedef enum logic [2:0] {
    AM_INHERENT,
    AM_IMMEDIATE,
    AM_DIRECT,
    AM_EXTENDED,
    AM_INDEXED0,
    AM_INDEXED8,
    AM_INDEXED16,
    AM_RELATIVE
  } addr_mode_t;

  typedef enum logic [2:0] {
    CLS_REG_MEM,
    CLS_RMW,
    CLS_JUMP_BRANCH,
    CLS_BIT_MANIP,
    CLS_CONTROL
  } instr_class_t;

  // branch condition select, low nibble of a relative opcode
  typedef enum logic [3:0] {
    COND_ALWAYS,
    COND_NEVER,
    COND_HIGHER,
    COND_LOWER_SAME,
    COND_CARRY_CLR,
    COND_CARRY_SET,
    COND_NOT_EQUAL,
    COND_EQUAL,
    COND_HALF_CLR,
    COND_HALF_SET,
    COND_PLUS,
    COND_MINUS,
    COND_MASK_CLR,
    COND_MASK_SET,
    COND_IRQ_LOW,
    COND_IRQ_HIGH
  } branch_cond_t;

endpackage

// [hdl/branch_cond_eval.sv]
/*
  Branch condition evaluator: resolves a relative-branch condition code
  against the condition flags and the external interrupt pin level.
  Assumes flags and pin level are already synchronous to the clock.
*/
module branch_cond_eval
  import idec_pkg::*;
(
  // condition select
  input  wire logic [3:0] cond_sel_i,
  // flags
  input  wire logic       half_i,
  input  wire logic       mask_i,
  input  wire logic       neg_i,
  input  wire logic       zero_i,
  input  wire logic       carry_i,
  input  wire logic       irq_pin_i,
  // result
  output logic            taken_o
);

  always_comb
  begin
    unique case (branch_cond_t'(cond_sel_i))
      COND_ALWAYS:     taken_o = 1'b1;
      COND_NEVER:      taken_o = 1'b0;
      COND_HIGHER:     taken_o = ~(carry_i | zero_i);
      COND_LOWER_SAME: taken_o = carry_i | zero_i;
      COND_CARRY_CLR:  taken_o = ~carry_i;
      COND_CARRY_SET:  taken_o = carry_i;
      COND_NOT_EQUAL:  taken_o = ~zero_i;
      COND_EQUAL:      taken_o = zero_i;
      COND_HALF_CLR:   taken_o = ~half_i;
      COND_HALF_SET:   taken_o = half_i;
      COND_PLUS:       taken_o = ~neg_i;
      COND_MINUS:      taken_o = neg_i;
      COND_MASK_CLR:   taken_o = ~mask_i;
      COND_MASK_SET:   taken_o = mask_i;
      COND_IRQ_LOW:    taken_o = ~irq_pin_i;
      COND_IRQ_HIGH:   taken_o = irq_pin_i;
    endcase
  end

endmodule

// [hdl/instr_decode.sv]
/*
  Instruction decoder: length, addressing mode, class, effective address,
  write-back and branch target for one instruction per request.
  Assumes the fetch unit presents the opcode and the two following bytes,
  and, for bit-test branches, the tested memory byte, together with the
  index register, program counter of the opcode and condition flags.
*/
module instr_decode
  import idec_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  // fetch side
  input  wire logic              req_valid_i,
  input  wire logic [7:0]        opcode_i,
  input  wire logic [7:0]        byte1_i,
  input  wire logic [7:0]        byte2_i,
  input  wire logic [15:0]       pc_i,
  // cpu state
  input  wire logic [7:0]        index_i,
  input  wire logic [7:0]        test_byte_i,
  input  wire logic              half_i,
  input  wire logic              mask_i,
  input  wire logic              neg_i,
  input  wire logic              zero_i,
  input  wire logic              carry_i,
  input  wire logic              irq_pin_i,
  // decode results
  output logic                   dec_valid_o,
  output logic [1:0]             length_o,
  output logic [2:0]             mode_o,
  output logic [2:0]             class_o,
  output logic                   mem_read_o,
  output logic                   mem_write_o,
  output logic                   reg_is_index_o,
  output logic [15:0]            eff_addr_o,
  output logic                   branch_o,
  output logic                   taken_o,
  output logic [15:0]            next_pc_o,
  output logic                   carry_load_o,
  output logic                   carry_val_o
);

  typedef struct packed {
    logic         rst_s1;
    logic         rst_s2;
    logic         valid;
    logic [1:0]   length;
    addr_mode_t   mode;
    instr_class_t cls;
    logic         mem_read;
    logic         mem_write;
    logic         reg_index;
    logic [15:0]  ea;
    logic         branch;
    logic         taken;
    logic [15:0]  next_pc;
    logic         carry_load;
    logic         carry_val;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   rst_n;
  logic   cond_taken;

  assign rst_n = state_reg.rst_s2;

  // length implied by each addressing mode
  function automatic logic [1:0] mode_length(input addr_mode_t m);
    unique case (m)
      AM_INHERENT:  mode_length = LEN_ONE;
      AM_IMMEDIATE: mode_length = LEN_TWO;
      AM_DIRECT:    mode_length = LEN_TWO;
      AM_EXTENDED:  mode_length = LEN_THREE;
      AM_INDEXED0:  mode_length = LEN_ONE;
      AM_INDEXED8:  mode_length = LEN_TWO;
      AM_INDEXED16: mode_length = LEN_THREE;
      AM_RELATIVE:  mode_length = LEN_TWO;
    endcase
  endfunction

  // sign-extended branch destination from the next instruction address
  function automatic logic [15:0] rel_target(input logic [15:0] nxt, input logic [7:0] off);
    rel_target = nxt + {{8{off[7]}}, off};
  endfunction

  branch_cond_eval u_cond (
    .cond_sel_i (opcode_i[OPC_COL_HI:OPC_COL_LO]),
    .half_i     (half_i),
    .mask_i     (mask_i),
    .neg_i      (neg_i),
    .zero_i     (zero_i),
    .carry_i    (carry_i),
    .irq_pin_i  (irq_pin_i),
    .taken_o    (cond_taken)
  );

  always_comb
  begin
    logic [3:0]  row;
    logic [3:0]  col;
    logic [15:0] seq_pc;
    logic        bit_val;
    row = opcode_i[OPC_ROW_HI:OPC_ROW_LO];
    col = opcode_i[OPC_COL_HI:OPC_COL_LO];
    seq_pc = 16'h0000;
    bit_val = 1'b0;
    state_next = state_reg;
    state_next.rst_s1 = 1'b1;
    state_next.rst_s2 = state_reg.rst_s1;
    state_next.valid = req_valid_i;
    if (req_valid_i)
    begin
      state_next.mode = AM_INHERENT;
      state_next.cls = CLS_CONTROL;
      state_next.mem_read = 1'b0;
      state_next.mem_write = 1'b0;
      state_next.reg_index = 1'b0;
      state_next.branch = 1'b0;
      state_next.taken = 1'b0;
      state_next.carry_load = 1'b0;
      state_next.carry_val = 1'b0;
      // decode mode and class from the opcode row
      unique case (row)
        ROW_BIT_BRANCH:
        begin
          state_next.mode = AM_DIRECT;
          state_next.cls = CLS_BIT_MANIP;
          state_next.mem_read = 1'b1;
          state_next.branch = 1'b1;
        end
        ROW_BIT_MANIP:
        begin
          state_next.mode = AM_DIRECT;
          state_next.cls = CLS_BIT_MANIP;
          state_next.mem_read = 1'b1;
          state_next.mem_write = 1'b1;
        end
        ROW_BRANCH:
        begin
          state_next.mode = AM_RELATIVE;
          state_next.cls = CLS_JUMP_BRANCH;
          state_next.branch = 1'b1;
        end
        ROW_RMW_DIR, ROW_RMW_IX1, ROW_RMW_IX:
        begin
          state_next.mode = (row == ROW_RMW_DIR) ? AM_DIRECT :
                            (row == ROW_RMW_IX1) ? AM_INDEXED8 : AM_INDEXED0;
          state_next.cls = CLS_RMW;
          state_next.mem_read = 1'b1;
          state_next.mem_write = (col != COL_RMW_TEST);
        end
        ROW_RMW_ACC, ROW_RMW_IDX:
        begin
          state_next.mode = AM_INHERENT;
          state_next.cls = (opcode_i == OPC_MULTIPLY) ? CLS_REG_MEM : CLS_RMW;
          state_next.reg_index = (row == ROW_RMW_IDX);
        end
        ROW_CTRL_A, ROW_CTRL_B:
        begin
          state_next.mode = AM_INHERENT;
          state_next.cls = CLS_CONTROL;
        end
        default:
        begin
          // register/memory rows A..F
          unique case (row)
            ROW_RM_IMM: state_next.mode = AM_IMMEDIATE;
            ROW_RM_DIR: state_next.mode = AM_DIRECT;
            ROW_RM_EXT: state_next.mode = AM_EXTENDED;
            ROW_RM_IX2: state_next.mode = AM_INDEXED16;
            ROW_RM_IX1: state_next.mode = AM_INDEXED8;
            default:    state_next.mode = AM_INDEXED0;
          endcase
          state_next.cls = CLS_REG_MEM;
          state_next.reg_index = (col == COL_INDEX_COMPARE) || (col >= COL_LDX);
          state_next.mem_read = (row != ROW_RM_IMM) && (col != COL_RM_STA)
                                && (col != COL_RM_STX) && (col != COL_UNCOND_JUMP)
                                && (col != COL_JUMP_SUBROUTINE);
          state_next.mem_write = (row != ROW_RM_IMM) &&
                                 ((col == COL_RM_STA) || (col == COL_RM_STX));
          if (row == ROW_RM_IMM && col == COL_BRANCH_SUBROUTINE)
          begin
            state_next.mode = AM_RELATIVE;
            state_next.cls = CLS_JUMP_BRANCH;
            state_next.branch = 1'b1;
            state_next.taken = 1'b1;
          end
          else if (col == COL_UNCOND_JUMP || col == COL_JUMP_SUBROUTINE)
          begin
            state_next.cls = CLS_JUMP_BRANCH;
            state_next.reg_index = 1'b0;
          end
        end
      endcase

      state_next.length = (row == ROW_BIT_BRANCH) ? LEN_THREE
                                                   : mode_length(state_next.mode);
      seq_pc = pc_i + {14'h0000, state_next.length};

      // effective address for memory-referencing modes
      unique case (state_next.mode)
        AM_DIRECT:    state_next.ea = {ZERO_PAGE_HI, byte1_i};
        AM_EXTENDED:  state_next.ea = {byte1_i, byte2_i};
        AM_INDEXED0:  state_next.ea = {ZERO_PAGE_HI, index_i};
        AM_INDEXED8:  state_next.ea = {8'h00, index_i} + {8'h00, byte1_i};
        AM_INDEXED16: state_next.ea = {byte1_i, byte2_i} + {8'h00, index_i};
        default:      state_next.ea = 16'h0000;
      endcase
      if (state_next.mode == AM_INHERENT && state_next.cls != CLS_CONTROL
          && row != ROW_RMW_ACC && row != ROW_RMW_IDX)
        state_next.ea = 16'h0000;

      // branch resolution
      if (row == ROW_BIT_BRANCH)
      begin
        bit_val = test_byte_i[opcode_i[BIT_NUM_HI:BIT_NUM_LO]];
        state_next.carry_load = 1'b1;
        state_next.carry_val = bit_val;
        state_next.taken = (bit_val == ~opcode_i[BIT_SENSE]);
        state_next.next_pc = state_next.taken ? rel_target(seq_pc, byte2_i) : seq_pc;
      end
      else if (state_next.branch)
      begin
        if (row == ROW_BRANCH)
          state_next.taken = cond_taken;
        state_next.next_pc = state_next.taken ? rel_target(seq_pc, byte1_i) : seq_pc;
      end
      else
        state_next.next_pc = seq_pc;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= '0;
    end
    else if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.rst_s1 <= 1'b1;
      state_reg.rst_s2 <= state_reg.rst_s1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dec_valid_o    = state_reg.valid;
  assign length_o       = state_reg.length;
  assign mode_o         = state_reg.mode;
  assign class_o        = state_reg.cls;
  assign mem_read_o     = state_reg.mem_read;
  assign mem_write_o    = state_reg.mem_write;
  assign reg_is_index_o = state_reg.reg_index;
  assign eff_addr_o     = state_reg.ea;
  assign branch_o       = state_reg.branch;
  assign taken_o        = state_reg.taken;
  assign next_pc_o      = state_reg.next_pc;
  assign carry_load_o   = state_reg.carry_load;
  assign carry_val_o    = state_reg.carry_val;

  // assertion history of the inputs
  logic [7:0]  opc_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic [7:0]  idx_q;
  logic [15:0] pc_q;
  always_ff @(posedge core_clk_i)
  begin
    opc_q <= opcode_i;
    b1_q <= byte1_i;
    b2_q <= byte2_i;
    idx_q <= index_i;
    pc_q <= pc_i;
  end

  sequence s_req;
    rst_n && req_valid_i;
  endsequence

  property p_direct_ea;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_DIRECT) |-> (eff_addr_o == {8'h00, b1_q} && length_o >= 2'h2);
  endproperty
  a_direct_ea: assert property (p_direct_ea) else $error("direct address wrong");

  property p_ext_ea;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_EXTENDED) |-> (eff_addr_o == {b1_q, b2_q} && length_o == 2'h3);
  endproperty
  a_ext_ea: assert property (p_ext_ea) else $error("extended address wrong");

  property p_ix0_ea;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_INDEXED0 && mem_read_o) |-> (eff_addr_o == {8'h00, idx_q});
  endproperty
  a_ix0_ea: assert property (p_ix0_ea) else $error("indexed address wrong");

  property p_ix8_ea;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_INDEXED8) |-> (eff_addr_o <= 16'h01FE && length_o == 2'h2
        && eff_addr_o == 16'({8'h00, idx_q} + {8'h00, b1_q}));
  endproperty
  a_ix8_ea: assert property (p_ix8_ea) else $error("indexed 8-bit sum out of range");

  property p_ix16_ea;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_INDEXED16) |->
        (eff_addr_o == 16'({b1_q, b2_q} + {8'h00, idx_q}) && length_o == 2'h3);
  endproperty
  a_ix16_ea: assert property (p_ix16_ea) else $error("indexed 16-bit sum wrong");

  property p_inh_len;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_INHERENT) |-> (length_o == 2'h1 && !mem_write_o);
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");

  property p_imm;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_IMMEDIATE) |-> (length_o == 2'h2 && !mem_read_o && !mem_write_o);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate decode wrong");

  property p_rel_target;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (mode_o == AM_RELATIVE && taken_o) |->
        (next_pc_o == 16'(pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q}));
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("branch target wrong");

  property p_not_taken;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (branch_o && !taken_o) |-> (next_pc_o == 16'(pc_q + {14'h0000, length_o}));
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("fall-through wrong");

  property p_test_no_write;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (class_o == CLS_RMW && opc_q[3:0] == 4'hD) |-> !mem_write_o;
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("test wrote memory");

  property p_bit_branch;
    @(posedge core_clk_i) disable iff (!rst_n)
      s_req ##1 (opc_q[7:4] == 4'h0) |-> (length_o == 2'h3 && carry_load_o
        && taken_o == (carry_val_o != opc_q[0]));
  endproperty
  a_bit_branch: assert property (p_bit_branch) else $error("bit branch wrong");

endmodule

// [test/bus_mem_model.sv]
/*
  Far-side model: the low-page memory byte that a bit-test branch reads.
  Assumes the fetch side hands the direct address and presents the byte
  on the same cycle as the decode request.
*/
module bus_mem_model
  import idec_pkg::*;
(
  // address
  input  wire logic [7:0] addr_i,
  // read data
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // fixed pattern so that every bit position takes both values
  assign data_o = addr_i ^ 8'h96;
endmodule

// [test/tb_top.sv]
/*
  Self-checking bench for the instruction decoder.
  Assumes one request per two cycles and results one cycle after it.
*/
module tb_top
  import idec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk, rstn, req, dvalid, br, tk, rd, wr, ridx, cld, cval;
  logic [7:0]  op, b1, b2, idx, tbyte;
  logic [15:0] pc, ea, npc;
  logic [5:0]  flg;
  logic [1:0]  len;
  logic [2:0]  mode, cls;
  int          n_mismatch, n_compared;

  bus_mem_model mem (.addr_i(b1), .data_o(tbyte));

  instr_decode dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .req_valid_i(req), .opcode_i(op),
    .byte1_i(b1), .byte2_i(b2), .pc_i(pc), .index_i(idx), .test_byte_i(tbyte),
    .half_i(flg[5]), .mask_i(flg[4]), .neg_i(flg[3]), .zero_i(flg[2]),
    .carry_i(flg[1]), .irq_pin_i(flg[0]), .dec_valid_o(dvalid), .length_o(len),
    .mode_o(mode), .class_o(cls), .mem_read_o(rd), .mem_write_o(wr),
    .reg_is_index_o(ridx), .eff_addr_o(ea), .branch_o(br), .taken_o(tk),
    .next_pc_o(npc), .carry_load_o(cld), .carry_val_o(cval)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input int cycles);
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    repeat (cycles) @(posedge core_clk);
    #1;
    chk(16'(dvalid), 16'h0000, "valid in reset");
    chk(ea, 16'h0000, "address in reset");
    rstn = 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // one request, outputs checked on the cycle the answer stands
  task automatic issue(input logic [7:0] o, a, b, input logic [15:0] p, input logic [7:0] x);
    @(posedge core_clk);
    #1;
    req = 1'b1;
    op = o;
    b1 = a;
    b2 = b;
    pc = p;
    idx = x;
    @(posedge core_clk);
    #1;
    req = 1'b0;
    op = ~o;
    idx = ~x;
    chk(16'(dvalid), 16'h0001, "valid");
  endtask

  task automatic mode_case(input logic [7:0] o, a, b, x, input logic [2:0] m,
                           input logic [1:0] l, input logic [2:0] c,
                           input logic [15:0] addr, input logic [1:0] rw);
    issue(o, a, b, 16'h0200, x);
    chk(16'(mode), 16'(m), "mode");
    chk(16'(len), 16'(l), "length");
    chk(16'(cls), 16'(c), "class");
    chk(ea, addr, "address");
    chk(16'({rd, wr}), 16'(rw), "read write");
  endtask

  task automatic t_modes();
    mode_case(8'h4C, 8'h11, 8'h22, 8'h33, 3'd0, 2'd1, 3'd1, 16'h0000, 2'b00);
    mode_case(8'hA6, 8'h55, 8'h22, 8'h33, 3'd1, 2'd2, 3'd0, 16'h0000, 2'b00);
    mode_case(8'hB6, 8'h80, 8'h22, 8'h33, 3'd2, 2'd2, 3'd0, 16'h0080, 2'b10);
    mode_case(8'hC6, 8'h12, 8'h34, 8'h33, 3'd3, 2'd3, 3'd0, 16'h1234, 2'b10);
    mode_case(8'hF6, 8'h12, 8'h34, 8'hFF, 3'd4, 2'd1, 3'd0, 16'h00FF, 2'b10);
    mode_case(8'hE6, 8'hFF, 8'h34, 8'hFF, 3'd5, 2'd2, 3'd0, 16'h01FE, 2'b10);
    mode_case(8'hD6, 8'hFF, 8'hF0, 8'h20, 3'd6, 2'd3, 3'd0, 16'h0010, 2'b10);
    mode_case(8'h3C, 8'h40, 8'h00, 8'h00, 3'd2, 2'd2, 3'd1, 16'h0040, 2'b11);
    mode_case(8'h3D, 8'h40, 8'h00, 8'h00, 3'd2, 2'd2, 3'd1, 16'h0040, 2'b10);
    mode_case(8'h42, 8'h40, 8'h00, 8'h00, 3'd0, 2'd1, 3'd0, 16'h0000, 2'b00);
    mode_case(8'h80, 8'h40, 8'h00, 8'h00, 3'd0, 2'd1, 3'd4, 16'h0000, 2'b00);
    mode_case(8'h13, 8'h22, 8'h00, 8'h00, 3'd2, 2'd2, 3'd3, 16'h0022, 2'b11);
    mode_case(8'hCC, 8'h12, 8'h34, 8'h00, 3'd3, 2'd3, 3'd2, 16'h1234, 2'b00);
    mode_case(8'hAD, 8'h10, 8'h00, 8'h00, 3'd7, 2'd2, 3'd2, 16'h0000, 2'b00);
    chk(16'(tk), 16'h0001, "subroutine branch taken");
    chk(npc, 16'h0212, "subroutine branch target");
    mode_case(8'hB7, 8'h10, 8'h00, 8'h00, 3'd2, 2'd2, 3'd0, 16'h0010, 2'b01);
    chk(16'(ridx), 16'h0000, "accumulator store");
    mode_case(8'hBF, 8'h10, 8'h00, 8'h00, 3'd2, 2'd2, 3'd0, 16'h0010, 2'b01);
    chk(16'(ridx), 16'h0001, "index store");
    // idle cycles drop valid but keep the last address
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(dvalid), 16'h0000, "idle valid");
    chk(ea, 16'h0010, "idle address");
  endtask

  function automatic logic cond_exp(input int k, input logic [5:0] f);
    case (k)
      0: return 1'b1;
      1: return 1'b0;
      2: return !(f[1] | f[2]);
      3: return f[1] | f[2];
      4: return !f[1];
      5: return f[1];
      6: return !f[2];
      7: return f[2];
      8: return !f[5];
      9: return f[5];
      10: return !f[3];
      11: return f[3];
      12: return !f[4];
      13: return f[4];
      14: return !f[0];
      default: return f[0];
    endcase
  endfunction

  task automatic t_branch();
    logic [5:0] pats [3];
    logic       t;
    pats = '{6'h00, 6'h3F, 6'h2A};
    for (int p = 0; p < 3; p++)
    begin
      for (int k = 0; k < 16; k++)
      begin
        flg = pats[p];
        t = cond_exp(k, pats[p]);
        issue({4'h2, 4'(k)}, 8'h80, 8'h00, 16'h0010, 8'h00);
        chk(16'(tk), 16'(t), "taken");
        chk(npc, t ? 16'hFF92 : 16'h0012, "branch target");
        chk(16'({br, mode, len}), 16'({1'b1, 3'd7, 2'd2}), "relative form");
      end
    end
  endtask

  task automatic t_bit_branch();
    logic [7:0] a;
    logic       bv, t;
    for (int n = 0; n < 8; n++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        a = 8'hC0 + 8'(n * 9);
        bv = 1'((a ^ 8'h96) >> n);
        t = (s == 0) ? bv : !bv;
        issue({4'h0, 3'(n), 1'(s)}, a, 8'h7F, 16'hFFF0, 8'h55);
        chk(16'(len), 16'h0003, "bit branch length");
        chk(ea, {8'h00, a}, "bit branch address");
        chk(16'(tk), 16'(t), "bit branch taken");
        chk(npc, t ? 16'h0072 : 16'hFFF3, "bit branch target");
        chk(16'({cld, cval}), 16'({1'b1, bv}), "carry copy");
      end
    end
  endtask

  initial
  begin
    rstn = 1'b0;
    req = 1'b0;
    op = 8'h00;
    b1 = 8'h00;
    b2 = 8'h00;
    pc = 16'h0000;
    idx = 8'h00;
    flg = 6'h00;
    n_mismatch = 0;
    n_compared = 0;
    do_reset(10);
    t_modes();
    t_branch();
    do_reset(2);
    t_bit_branch();
    summarize();
  end

  initial
  begin
    #20us;
    n_mismatch++;
    $display("Error %0t: run did not finish", $time);
    summarize();
  end
endmodule
